/* rtl/dpw_top.sv */
// Two-channel PWM generator with buffering, interlocks and pin steering
//
// Functional notes
// - Equal active rates make channels synchronous and add an A/B interlock.
// - Equal rates: a B duty write waits for an A duty write, then transfers.
// - Duty coupling between channels is off whenever the periods differ.
// - With equal rates a B control write waits for an A control write.
// - Control coupling between channels is off whenever the periods differ.
// - A/B and data/control interlocks may pend together, tracked apart.
// - Locked B duty write arms data/control lock; B control frees it.
// - Update bits clear: transfer at cycle end once all interlocks are met.
// - Update bit set: that channel transfers once its interlocks are met.
// - Direct duty writes arm no data/control lock; a direct B write arms the A/B one.
// - Locked A duty write arms channel A data/control interlock.
// - Unequal rates: channels independent, own buffering and interlock only.
// - Rate is buffered, not interlocked, and governs the next cycle.
// - Rate holds two 4-bit fields, each loaded at its channel's cycle end.
// - Generation continues normally in wait mode; no wait input exists.
// - Channel A goes to pin 1, pin 3 or pin 5 by its steer bits.
// - Mask enabled and steer clear: pin drives its mask level.
// - Duty writes land in the buffer; duty reads return the active value.
// - PWM reset stops counters and prescalers, frees pins, keeps duty.
// - Locked duty stays pending until its control write, then transfers at cycle end, or at once with update set.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module dpw_top #(
   parameter int CNT_W = 8,
   parameter int RATE_W = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Port pins 1..6 (index 0 = pin 1); enable high while PWM owns the pin
   output logic [5:0] pin_o,
   output logic [5:0] pin_oe_o
);

   // ----------------------------------------------------------------------
   // Declarations (channel 0 = A, channel 1 = B)
   // ----------------------------------------------------------------------
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic [CNT_W-1:0] duty_buf_reg [2];
   logic [CNT_W-1:0] duty_act_reg [2];
   dpw_pkg::dpw_ctl_type ctl_buf_reg [2];
   dpw_pkg::dpw_ctl_type ctl_act_reg [2];
   logic [RATE_W-1:0] rate_buf_reg [2];
   logic [RATE_W-1:0] rate_act_reg [2];
   logic [1:0] update_reg;
   logic [1:0] data_dirty_reg;
   logic [1:0] ctl_dirty_reg;
   logic [1:0] dc_pend_reg;
   logic ab_data_pend_reg;
   logic ab_ctl_pend_reg;
   logic [dpw_pkg::PRESC_W-1:0] presc_reg [2];
   logic [CNT_W-1:0] cnt_reg [2];
   dpw_pkg::dpw_pin_type pin_reg [6];

   logic bus_req;
   logic wr_stb;
   logic [5:0] idx;
   logic [1:0] wr_duty;
   logic [1:0] wr_locked;
   logic [1:0] wr_ctl;
   logic rates_equal;
   logic preset;
   logic [1:0] presc_wrap;
   logic [1:0] cyc_end;
   logic [1:0] satisfied;
   logic [1:0] commit;
   logic [1:0] wave;
   logic [31:0] rdata_next;

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   // A request is taken once; the ack cycle blocks a second take
   assign bus_req = cyc_i & stb_i & ~ack_reg;
   assign wr_stb = bus_req & we_i & sel_i[0];
   assign idx = adr_i[7:2];
   assign wr_duty[0] = wr_stb & ((idx == dpw_pkg::IDX_DUTY_A_DIRECT) |
                                 (idx == dpw_pkg::IDX_DUTY_A_LOCKED));
   assign wr_duty[1] = wr_stb & ((idx == dpw_pkg::IDX_DUTY_B_DIRECT) |
                                 (idx == dpw_pkg::IDX_DUTY_B_LOCKED));
   assign wr_locked[0] = wr_stb & (idx == dpw_pkg::IDX_DUTY_A_LOCKED);
   assign wr_locked[1] = wr_stb & (idx == dpw_pkg::IDX_DUTY_B_LOCKED);
   assign wr_ctl[0] = wr_stb & (idx == dpw_pkg::IDX_CHANNEL_FIRST_CONTROL);
   assign wr_ctl[1] = wr_stb & (idx == dpw_pkg::IDX_CHANNEL_B_CONTROL);

   // ----------------------------------------------------------------------
   // Channel status terms
   // ----------------------------------------------------------------------
   // Equality from active fields only, so it moves at cycle ends
   assign rates_equal = (rate_act_reg[0] == rate_act_reg[1]);

   // All mask enables and steer bits clear means PWM reset
   assign preset = ~(ctl_act_reg[0].mask_enable | (|ctl_act_reg[0].steer) |
                     ctl_act_reg[1].mask_enable |
                     (|ctl_act_reg[1].steer));

   // Per-channel cycle end, interlock state and transfer strobe
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         presc_wrap[c] = (presc_reg[c] ==
                          dpw_pkg::PRESC_W'((32'h1 << rate_act_reg[c]) - 1));
         // In reset no cycle runs, so buffered values pass at once
         cyc_end[c] = preset |
                      (presc_wrap[c] & (cnt_reg[c] == dpw_pkg::CNT_LAST));
         // A/B flags only count while the rates match
         satisfied[c] = ~dc_pend_reg[c] &
                        (~rates_equal |
                         ~(ab_data_pend_reg | ab_ctl_pend_reg));
         commit[c] = satisfied[c] &
                     (update_reg[c] | cyc_end[c]);
         wave[c] = (cnt_reg[c] < duty_act_reg[c]) ^
                   ctl_act_reg[c].polarity;
      end
   end

   // ----------------------------------------------------------------------
   // Buffer registers written by software
   // ----------------------------------------------------------------------
   // Duty buffers carry no reset: their contents survive every reset
   always_ff @(posedge clk_i) begin
      for (int c = 0; c < 2; c++) begin
         if (wr_duty[c]) begin
            duty_buf_reg[c] <= dat_i[CNT_W-1:0];
         end
      end
   end

   // Control, rate and update buffers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_buf_reg[0] <= dpw_pkg::CTL_RESET;
         ctl_buf_reg[1] <= dpw_pkg::CTL_RESET;
         rate_buf_reg[0] <= dpw_pkg::RATE_RESET;
         rate_buf_reg[1] <= dpw_pkg::RATE_RESET;
         update_reg <= dpw_pkg::UPDATE_RESET;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (wr_ctl[c]) begin
               ctl_buf_reg[c] <= dat_i[7:0];
            end
         end
         if (wr_stb && idx == dpw_pkg::IDX_RATE) begin
            rate_buf_reg[0] <= dat_i[dpw_pkg::RATE_A_LSB +: RATE_W];
            rate_buf_reg[1] <= dat_i[dpw_pkg::RATE_B_LSB +: RATE_W];
         end
         if (wr_stb && idx == dpw_pkg::IDX_UPDATE) begin
            update_reg[0] <= dat_i[dpw_pkg::UPDATE_A_BIT];
            update_reg[1] <= dat_i[dpw_pkg::UPDATE_B_BIT];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Dirty flags: a new write wins over a transfer in the same cycle
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_dirty_reg <= 2'h0;
         ctl_dirty_reg <= 2'h0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (wr_duty[c]) begin
               data_dirty_reg[c] <= 1'b1;
            end else if (commit[c]) begin
               data_dirty_reg[c] <= 1'b0;
            end
            if (wr_ctl[c]) begin
               ctl_dirty_reg[c] <= 1'b1;
            end else if (commit[c]) begin
               ctl_dirty_reg[c] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Data/control interlock per channel
   // ----------------------------------------------------------------------
   // Armed by a locked-address write, released by that channel's control
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dc_pend_reg <= 2'h0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (wr_locked[c]) begin
               dc_pend_reg[c] <= 1'b1;
            end else if (wr_ctl[c]) begin
               dc_pend_reg[c] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Channel A/B interlock
   // ----------------------------------------------------------------------
   // Both address kinds count; only channel A writes or unequal rates release it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ab_data_pend_reg <= 1'b0;
         ab_ctl_pend_reg <= 1'b0;
      end else if (!rates_equal) begin
         ab_data_pend_reg <= 1'b0;
         ab_ctl_pend_reg <= 1'b0;
      end else begin
         if (wr_duty[1]) begin
            ab_data_pend_reg <= 1'b1;
         end else if (wr_duty[0]) begin
            ab_data_pend_reg <= 1'b0;
         end
         if (wr_ctl[1]) begin
            ab_ctl_pend_reg <= 1'b1;
         end else if (wr_ctl[0]) begin
            ab_ctl_pend_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Active registers
   // ----------------------------------------------------------------------
   // Duty moves only on a transfer, never on reset
   always_ff @(posedge clk_i) begin
      for (int c = 0; c < 2; c++) begin
         if (commit[c] && data_dirty_reg[c]) begin
            duty_act_reg[c] <= duty_buf_reg[c];
         end
      end
   end

   // Control cleared by reset; rate follows each channel's own cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_act_reg[0] <= dpw_pkg::CTL_RESET;
         ctl_act_reg[1] <= dpw_pkg::CTL_RESET;
         rate_act_reg[0] <= dpw_pkg::RATE_RESET;
         rate_act_reg[1] <= dpw_pkg::RATE_RESET;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (commit[c] && ctl_dirty_reg[c]) begin
               ctl_act_reg[c] <= ctl_buf_reg[c];
            end
            // No interlock on rate, so no glitch mid-cycle
            if (cyc_end[c]) begin
               rate_act_reg[c] <= rate_buf_reg[c];
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Prescaler and 8-bit cycle counter per channel
   // ----------------------------------------------------------------------
   // Runs whatever the processor's power mode; only reset or PWM reset stops it
   always_ff @(posedge clk_i) begin
      if (rst_i || preset) begin
         for (int c = 0; c < 2; c++) begin
            presc_reg[c] <= '0;
            cnt_reg[c] <= '0;
         end
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (presc_wrap[c]) begin
               presc_reg[c] <= '0;
               cnt_reg[c] <= cnt_reg[c] + 1'b1;
            end else begin
               presc_reg[c] <= presc_reg[c] + 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Pin steering: pin index 2*j+c, A on odd pins, B on even pins
   // ----------------------------------------------------------------------
   for (genvar c = 0; c < 2; c++) begin : g_chan
      for (genvar j = 0; j < 3; j++) begin : g_pin
         always_ff @(posedge clk_i) begin
            if (rst_i || preset) begin
               pin_reg[2*j+c] <= '0;
            end else if (ctl_act_reg[c].steer[j]) begin
               pin_reg[2*j+c].drive <= 1'b1;
               pin_reg[2*j+c].level <= wave[c];
            end else begin
               pin_reg[2*j+c].drive <= ctl_act_reg[c].mask_enable;
               pin_reg[2*j+c].level <= ctl_act_reg[c].mask_enable &
                                       ctl_act_reg[c].mask_level[j];
            end
         end
         assign pin_o[2*j+c] = pin_reg[2*j+c].level;
         assign pin_oe_o[2*j+c] = pin_reg[2*j+c].drive;
      end
   end

   // ----------------------------------------------------------------------
   // Read mux: duty reads return the active value
   // ----------------------------------------------------------------------
   always_comb begin
      rdata_next = dpw_pkg::WB_ZERO;
      unique case (idx)
         dpw_pkg::IDX_DUTY_A_DIRECT,
         dpw_pkg::IDX_DUTY_A_LOCKED: begin
            rdata_next[CNT_W-1:0] = duty_act_reg[0];
         end
         dpw_pkg::IDX_DUTY_B_DIRECT,
         dpw_pkg::IDX_DUTY_B_LOCKED: begin
            rdata_next[CNT_W-1:0] = duty_act_reg[1];
         end
         dpw_pkg::IDX_CHANNEL_FIRST_CONTROL: begin
            rdata_next[7:0] = ctl_buf_reg[0];
         end
         dpw_pkg::IDX_CHANNEL_B_CONTROL: begin
            rdata_next[7:0] = ctl_buf_reg[1];
         end
         dpw_pkg::IDX_RATE: begin
            rdata_next[dpw_pkg::RATE_A_LSB +: RATE_W] = rate_buf_reg[0];
            rdata_next[dpw_pkg::RATE_B_LSB +: RATE_W] = rate_buf_reg[1];
         end
         dpw_pkg::IDX_UPDATE: begin
            rdata_next[1:0] = update_reg;
         end
         dpw_pkg::IDX_STATUS: begin
            rdata_next[7:0] = {preset, rates_equal, ab_ctl_pend_reg,
                               ab_data_pend_reg, ctl_dirty_reg[1],
                               data_dirty_reg[1], dc_pend_reg};
         end
         default: begin
            rdata_next = dpw_pkg::WB_ZERO; // Unmapped reads as zero
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Wishbone answer: ack one cycle after the request, for one cycle
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         rdata_reg <= dpw_pkg::WB_ZERO;
      end else begin
         ack_reg <= bus_req;
         if (bus_req && !we_i) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   assign ack_o = ack_reg;
   assign dat_o = rdata_reg;

endmodule

`default_nettype wire

/* rtl/dpw_pkg.sv */
// Package: register map, field layouts and constants of the dual PWM block
package dpw_pkg;

   // ----------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------------
   localparam logic [5:0] IDX_DUTY_A_DIRECT = 6'h10;
   localparam logic [5:0] IDX_DUTY_A_LOCKED = 6'h11;
   localparam logic [5:0] IDX_DUTY_B_DIRECT = 6'h12;
   localparam logic [5:0] IDX_DUTY_B_LOCKED = 6'h13;
   localparam logic [5:0] IDX_CHANNEL_FIRST_CONTROL = 6'h14;
   localparam logic [5:0] IDX_CHANNEL_B_CONTROL = 6'h15;
   localparam logic [5:0] IDX_RATE = 6'h16;
   localparam logic [5:0] IDX_UPDATE = 6'h17;
   localparam logic [5:0] IDX_STATUS = 6'h18;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int RATE_A_LSB = 0;
   localparam int RATE_B_LSB = 4;
   localparam int UPDATE_A_BIT = 0;
   localparam int UPDATE_B_BIT = 1;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [3:0] RATE_RESET = 4'h0;
   localparam logic [1:0] UPDATE_RESET = 2'h0;
   localparam logic [31:0] WB_ZERO = 32'h00000000;

   // ----------------------------------------------------------------------
   // Timing: cycle counter terminal value and prescaler width
   // ----------------------------------------------------------------------
   localparam logic [7:0] CNT_LAST = 8'hFF;
   localparam int PRESC_W = 16;

   // ----------------------------------------------------------------------
   // Channel control register layout, MSB first
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic       polarity;
      logic [2:0] mask_level;   // Bit 0 pin1/2, bit 1 pin3/4, bit 2 pin5/6
      logic       mask_enable;
      logic [2:0] steer;        // Same pin order as mask_level
   } dpw_ctl_type;

   // Pin drive pair carried together
   typedef struct packed {
      logic level;
      logic drive;
   } dpw_pin_type;

endpackage

/* bench/dpw_assertions.sv */
// Checker: bus handshake, read data and pin release of the PWM block
`timescale 1ns/100ps
`default_nettype none
module dpw_checker #(
   parameter int CNT_W = 8,
   parameter int RATE_W = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone side
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // Port pins
   input wire logic [5:0] pin_o,
   input wire logic [5:0] pin_oe_o
);
   logic take;
   logic unmapped;
   logic ctl_seen_reg;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ---------------------------------------------------------------
   // Helper logic
   // ---------------------------------------------------------------
   // Request taken on this edge
   assign take = cyc_i && stb_i && !ack_o;
   assign unmapped = adr_i[7:2] < 6'h10 || adr_i[7:2] > 6'h18;
   // Pins may only come up once a control byte was written
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_seen_reg <= 1'b0;
      end else if (take && we_i && adr_i[7:3] == 5'h0A) begin
         ctl_seen_reg <= 1'b1;
      end
   end
   sequence s_take;
      take;
   endsequence
   sequence s_answer;
      ack_o ##1 !ack_o;
   endsequence
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   a_bus_walk: assert property (s_take |=> s_answer)
      else $error("ack not a single pulse one cycle after request");
   a_ack_cause: assert property (ack_o |-> $past(take))
      else $error("ack without a taken request");
   a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o
      && dat_o == 32'h00000000 && pin_oe_o == 6'h00 && pin_o == 6'h00)
      else $error("outputs not cleared by reset");
   a_unmapped_zero: assert property (take && !we_i && unmapped
      |=> dat_o == 32'h00000000)
      else $error("unmapped read not zero");
   a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   a_dat_hold: assert property ($changed(dat_o) |-> ack_o
      && $past(we_i) == 1'b0)
      else $error("read data moved without a read");
   a_write_keeps: assert property (take && we_i |=> $stable(dat_o))
      else $error("write disturbed read data");
   a_idle_released: assert property (
      !ctl_seen_reg |-> pin_oe_o == 6'h00)
      else $error("pins driven before any control write");
endmodule
bind dpw_top dpw_checker #(.CNT_W(CNT_W), .RATE_W(RATE_W)) u_dpw_checker (
   .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
   .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .dat_o(dat_o), .ack_o(ack_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o)
);
`default_nettype wire

/* bench/dpw_bridge_model.sv */
// Model of the external switch stage fed by the six port pins
`timescale 1ns/100ps
`default_nettype none
module dpw_bridge_model (
   // Clock and pins from the block
   input wire logic clk_i,
   input wire logic [5:0] pin_i,
   input wire logic [5:0] pin_oe_i,
   // Gate levels seen by the switches
   output logic [5:0] pad_o
);
   logic [5:0] last_reg = 6'h00;
   // Released pad floats: show a level that flips, never a held value
   always_comb begin
      for (int k = 0; k < 6; k++) begin
         pad_o[k] = pin_oe_i[k] ? pin_i[k] : ~last_reg[k];
      end
   end
   // Remember the last pad level
   always_ff @(posedge clk_i) begin
      last_reg <= pad_o;
   end
endmodule
`default_nettype wire

/* bench/dpw_top_test.sv */
// Self-checking bench for the dual PWM block
`timescale 1ns/100ps
`default_nettype none
module dpw_top_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h00000000;
   logic [3:0] sel_i = 4'h0;
   logic we_i = 1'b0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic [31:0] dat_o;
   logic ack_o;
   logic [5:0] pin_o;
   logic [5:0] pin_oe_o;
   logic [5:0] pad;
   logic [7:0] exp_q[$];
   logic [31:0] rng = 32'h4E7AD71C;
   int fail_count = 0;
   int n_checks = 0;
   int cycles = 0;
   int hi;
   // 20 MHz clock
   always #25 clk_i = ~clk_i;
   dpw_top u_dpw_top (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
      .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .pin_o(pin_o),
      .pin_oe_o(pin_oe_o));
   dpw_bridge_model u_dpw_bridge_model (.clk_i(clk_i), .pin_i(pin_o),
      .pin_oe_i(pin_oe_o), .pad_o(pad));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // One classic cycle; held until ack is sampled, then released
   task automatic bus(input logic [5:0] idx, input logic w,
                      input logic [7:0] d, input logic [3:0] s);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= s;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h000000, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      bus(idx, 1'b1, d, 4'h1);
   endtask
   task automatic rd(input logic [5:0] idx, input logic [7:0] e);
      exp_q.push_back(e);
      bus(idx, 1'b0, 8'h00, 4'hF);
   endtask
   // Count high pad cycles over one 256-clock period
   task automatic count_hi(input int k);
      hi = 0;
      repeat (256) begin
         @(posedge clk_i);
         if (pad[k] === 1'b1) hi++;
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Monitor and timeout
   // ---------------------------------------------------------------
   // Oldest read expectation meets the data of each read ack
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
         check("rdata", dat_o, {24'h000000, exp_q.pop_front()});
      end
   end
   // Whole run needs some 1500 cycles; a hang stops here
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(dpw_pkg::IDX_CHANNEL_FIRST_CONTROL, 8'h00);
      rd(dpw_pkg::IDX_RATE, 8'h00);
      rd(dpw_pkg::IDX_UPDATE, 8'h00);
      rd(dpw_pkg::IDX_STATUS, 8'hC0);
      bus(dpw_pkg::IDX_CHANNEL_B_CONTROL, 1'b1, 8'hFF, 4'hE);
      wr(6'h02, 8'hFF);
      rd(6'h02, 8'h00);
      rd(dpw_pkg::IDX_CHANNEL_B_CONTROL, 8'h00);
      $display("test reset values done");
      // Equal rates: B duty waits for an A duty write
      wr(dpw_pkg::IDX_DUTY_B_DIRECT, 8'h33);
      wr(dpw_pkg::IDX_DUTY_A_DIRECT, 8'h5A);
      rd(dpw_pkg::IDX_DUTY_B_LOCKED, 8'h33);
      rd(dpw_pkg::IDX_DUTY_A_LOCKED, 8'h5A);
      wr(dpw_pkg::IDX_DUTY_B_DIRECT, 8'h77);
      rd(dpw_pkg::IDX_DUTY_B_DIRECT, 8'h33);
      wr(dpw_pkg::IDX_DUTY_A_DIRECT, 8'h11);
      rd(dpw_pkg::IDX_DUTY_B_DIRECT, 8'h77);
      // Both interlocks pending on channel B at once
      wr(dpw_pkg::IDX_DUTY_B_LOCKED, 8'h44);
      wr(dpw_pkg::IDX_DUTY_A_DIRECT, 8'h22);
      rd(dpw_pkg::IDX_DUTY_B_DIRECT, 8'h77);
      wr(dpw_pkg::IDX_CHANNEL_B_CONTROL, 8'h00);
      rd(dpw_pkg::IDX_DUTY_B_DIRECT, 8'h77);
      wr(dpw_pkg::IDX_CHANNEL_FIRST_CONTROL, 8'h00);
      rd(dpw_pkg::IDX_DUTY_B_DIRECT, 8'h44);
      // Locked A write that satisfies the A/B interlock
      wr(dpw_pkg::IDX_DUTY_B_DIRECT, 8'h10);
      wr(dpw_pkg::IDX_DUTY_A_LOCKED, 8'h20);
      rd(dpw_pkg::IDX_DUTY_A_DIRECT, 8'h22);
      wr(dpw_pkg::IDX_CHANNEL_FIRST_CONTROL, 8'h00);
      rd(dpw_pkg::IDX_DUTY_A_DIRECT, 8'h20);
      rd(dpw_pkg::IDX_DUTY_B_DIRECT, 8'h10);
      $display("test interlocks done");
      // Unequal rates: channels run independently
      wr(dpw_pkg::IDX_RATE, 8'h10);
      rd(dpw_pkg::IDX_STATUS, 8'h80);
      wr(dpw_pkg::IDX_DUTY_B_DIRECT, 8'h55);
      rd(dpw_pkg::IDX_DUTY_B_DIRECT, 8'h55);
      wr(dpw_pkg::IDX_CHANNEL_B_CONTROL, 8'h00);
      rd(dpw_pkg::IDX_STATUS, 8'h80);
      rd(dpw_pkg::IDX_RATE, 8'h10);
      wr(dpw_pkg::IDX_RATE, 8'h00);
      $display("test unequal rates done");
      // Pin 1 PWM, pin 3 mask high, pin 5 mask low
      wr(dpw_pkg::IDX_CHANNEL_FIRST_CONTROL, 8'h29);
      repeat (4) @(posedge clk_i);
      count_hi(0);
      check("pin1 high count", hi, 32);
      check("pin3 level", {pin_oe_o[2], pad[2]}, 2'b11);
      check("pin5 level", {pin_oe_o[4], pad[4]}, 2'b10);
      wr(dpw_pkg::IDX_CHANNEL_FIRST_CONTROL, 8'h0A);
      repeat (300) @(posedge clk_i);
      count_hi(2);
      check("pin3 high count", hi, 32);
      check("pin1 level", {pin_oe_o[0], pad[0]}, 2'b10);
      // Running: duty waits for the cycle end, then for nothing
      wr(dpw_pkg::IDX_DUTY_A_DIRECT, 8'h80);
      rd(dpw_pkg::IDX_DUTY_A_DIRECT, 8'h20);
      repeat (260) @(posedge clk_i);
      rd(dpw_pkg::IDX_DUTY_A_DIRECT, 8'h80);
      wr(dpw_pkg::IDX_UPDATE, 8'h01);
      repeat (4) begin
         rng = xs(rng);
         wr(dpw_pkg::IDX_DUTY_A_DIRECT, rng[7:0]);
         rd(dpw_pkg::IDX_DUTY_A_LOCKED, rng[7:0]);
      end
      $display("test running pins done");
      // Back to PWM reset: pins freed, duty kept
      wr(dpw_pkg::IDX_CHANNEL_FIRST_CONTROL, 8'h00);
      repeat (4) @(posedge clk_i);
      check("pins released", pin_oe_o, 6'h00);
      rd(dpw_pkg::IDX_STATUS, 8'hC0);
      rd(dpw_pkg::IDX_DUTY_A_DIRECT, rng[7:0]);
      repeat (4) @(posedge clk_i);
      check("reads left over", exp_q.size(), 0);
      $display("test pwm reset done");
      // Inverted wave on pin 1 from the duty kept through PWM reset
      wr(dpw_pkg::IDX_CHANNEL_FIRST_CONTROL, 8'h81);
      repeat (4) @(posedge clk_i);
      count_hi(0);
      check("pin1 inverted count", hi, 256 - rng[7:0]);
      $display("test polarity done");
      wrap_up();
   end
endmodule
`default_nettype wire
